// [inc/scmr_defines.vh]
// Constants for the synthesizer control and modulation register bank.
// Assumes a 25 MHz core clock; serial pins are asynchronous to it.
`ifndef SCMR_DEFINES_VH
`define SCMR_DEFINES_VH
`define SCMR_ADDR_PHASE 4'h6
`define SCMR_ADDR_POWER 4'h7
`define SCMR_ADDR_MODCFG 4'h8
`define SCMR_ADDR_SAMPLE 4'h9
`define SCMR_ADDR_BITS 4
`define SCMR_DATA_BITS 12
`define SCMR_FRAME_BITS 16
`define SCMR_SAMPLE_MIN 2
`define SCMR_SAMPLE_MAX 12
`define SCMR_MAG_MAX 4'hD
`define SCMR_RESET_VAL 12'h000
// Field positions, phase register
`define SCMR_GAIN_LSB 0
`define SCMR_GAIN_MSB 4
`define SCMR_STEER_BIT 5
// Field positions, power register
`define SCMR_FULLPD_BIT 0
`define SCMR_SYNPD_BIT 1
`define SCMR_INTMODE_BIT 2
`define SCMR_FRAC10_BIT 3
`define SCMR_TRI_BIT 4
`define SCMR_MON_LSB 6
`define SCMR_MON_MSB 8
// Field positions, modulation config register
`define SCMR_MAG_LSB 0
`define SCMR_MAG_MSB 3
`define SCMR_MODIN_BIT 4
`define SCMR_NOADDR_BIT 5
// Monitor codes
`define SCMR_MON_OSC 3'h0
`define SCMR_MON_REF 3'h2
`define SCMR_MON_PD 3'h4
`define SCMR_MON_LOOP 3'h5
`define SCMR_MON_TEST 3'h6
// Gain: current in units of 31.25 uA is code plus one
`define SCMR_GAIN_STEP_NA 31250
`define SCMR_FIFO_DEPTH 4
`define SCMR_CLK_PERIOD_NS 40
`endif

// [src/scmr_sync.v]
// Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes each bit is an independent level.
`timescale 1ns/1ns
module scmr_sync #(
	parameter W = 1
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Levels
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end
	assign q = sync_q;
endmodule

// [src/scmr_fifo.v]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; read data come from a register.
`timescale 1ns/1ns
module scmr_fifo #(
	parameter W = 12,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_q;
	reg [AW:0] rd_q;
	reg [W-1:0] dout_q;
	reg dval_q;
	wire [AW:0] used = wr_q - rd_q;
	wire full = (used == DEPTH[AW:0]);
	wire mem_empty = (wr_q == rd_q);
	wire push = in_valid && !full;
	// Output register refills when empty or being taken
	wire pop = !mem_empty && (!dval_q || out_ready);
	assign in_ready = !full;
	assign out_valid = dval_q;
	assign out_data = dout_q;
	always @(posedge clk) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
			dout_q <= {W{1'b0}};
			dval_q <= 1'b0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
				dout_q <= mem[rd_q[AW-1:0]];
				dval_q <= 1'b1;
			end else if (out_ready) begin
				dval_q <= 1'b0;
			end
		end
	end
endmodule

// [src/scmr_top.v]
// Serial-loaded control registers and direct modulation path.
// Assumes strobe, serial clock, data, modulation pin and compare clock
// are asynchronous and much slower than core_clk.
`timescale 1ns/1ns
`include "scmr_defines.vh"
module scmr_top #(
	parameter DW = 12,
	parameter DEPTH = 4,
	parameter MAG_W = 4
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Serial port
	input wire ser_cs_n,
	input wire ser_clk,
	input wire ser_data,
	input wire modulation_input_pin,
	// Timing references
	input wire ref_osc,
	input wire divided_reference,
	input wire phase_compare_clock,
	input wire serial_test_out,
	// Lock status and steering request from the loop
	input wire locked,
	input wire steer_req,
	// Lock/steer pin, open-collector for lock, driven high while steering, oe low drives
	output wire lock_detect_steer_o,
	output wire lock_detect_steer_oe_n,
	// Monitor pin, oe low drives
	output wire monitor_output_o,
	output wire monitor_output_oe_n,
	// Analog and modulator controls
	output reg [4:0] pump_gain,
	output reg full_power_down,
	output reg synth_power_down,
	output reg integer_mode,
	output reg sigma_delta_off,
	output reg frac_10bit,
	// Offset to add to channel center, in fine modulator steps
	output reg signed [DW+13-1:0] freq_offset,
	output reg offset_valid
);
	// Sync serial, modulation, compare clock and lock pins
	wire [5:0] pins_s;
	scmr_sync #(
		.W(6)
	) u_sync (
		.clk(core_clk),
		.rst(rst),
		.d({
			ser_cs_n,
			ser_clk,
			ser_data,
			modulation_input_pin,
			phase_compare_clock,
			locked
		}),
		.q(pins_s)
	);
	wire cs_n_s = pins_s[5];
	wire sclk_s = pins_s[4];
	wire sdat_s = pins_s[3];
	wire min_s = pins_s[2];
	wire pcc_s = pins_s[1];
	wire lock_s = pins_s[0];

	// Monitor sources and steering level are pins too; two flops first
	wire [3:0] aux_s;
	scmr_sync #(
		.W(4)
	) u_sync_aux (
		.clk(core_clk),
		.rst(rst),
		.d({ref_osc, divided_reference, serial_test_out, steer_req}),
		.q(aux_s)
	);
	wire osc_s = aux_s[3];
	wire dref_s = aux_s[2];
	wire test_s = aux_s[1];
	wire steer_s = aux_s[0];

	reg cs_prev_q;
	reg sclk_prev_q;
	reg pcc_prev_q;
	reg [15:0] shift_q;
	reg [4:0] count_q;
	reg [11:0] phase_q;
	reg [11:0] power_q;
	reg [11:0] modcfg_q;
	reg [11:0] sample_q;
	reg [3:0] width_q;
	reg [3:0] fifo_width_q;

	wire sclk_rise = sclk_s && !sclk_prev_q;
	// Strobe phase: a fall must come before a rise commits, so the low
	// synchroniser level straight after reset never looks like a frame end
	localparam ST_IDLE = 2'b00;
	localparam ST_SHIFT = 2'b01;
	localparam ST_DONE = 2'b10;
	reg [1:0] port_st_q;
	reg [1:0] port_st_d;
	wire cs_fall = !cs_n_s && cs_prev_q;
	always @* begin
		port_st_d = port_st_q;
		case (port_st_q)
			ST_IDLE: begin
				if (cs_fall) begin
					port_st_d = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (cs_n_s) begin
					port_st_d = ST_DONE;
				end
			end
			default: begin
				port_st_d = ST_IDLE;
			end
		endcase
	end
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			port_st_q <= ST_IDLE;
		end else begin
			port_st_q <= port_st_d;
		end
	end
	wire cs_rise = (port_st_q == ST_SHIFT) && cs_n_s;
	wire pcc_fall = !pcc_s && pcc_prev_q;
	wire use_modin = modcfg_q[`SCMR_MODIN_BIT];
	wire no_addr = modcfg_q[`SCMR_NOADDR_BIT];

	wire bit_in = use_modin ? min_s : sdat_s;

	// shift MSB first on clock rise
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cs_prev_q <= 1'b0;
			sclk_prev_q <= 1'b0;
			pcc_prev_q <= 1'b0;
			shift_q <= 16'h0000;
			count_q <= 5'h00;
		end else begin
			cs_prev_q <= cs_n_s;
			sclk_prev_q <= sclk_s;
			pcc_prev_q <= pcc_s;
			if (cs_n_s) begin
				count_q <= 5'h00;
			end else if (sclk_rise && count_q != 5'h1F) begin
				shift_q <= {shift_q[14:0], bit_in};
				count_q <= count_q + 5'h01;
			end
		end
	end

	// Strobe rise decode
	wire full_frame = (count_q == `SCMR_FRAME_BITS);
	wire [3:0] frame_addr = shift_q[15:12];
	wire [11:0] frame_data = shift_q[11:0];
	function len_ok;
		input [4:0] n;
		begin
			len_ok = (n >= `SCMR_SAMPLE_MIN) && (n <= `SCMR_SAMPLE_MAX);
		end
	endfunction
	wire short_ok = no_addr && len_ok(count_q);
	// addressed sample only without address disable
	wire addr_sample = full_frame && !no_addr && frame_addr == `SCMR_ADDR_SAMPLE;

	// sign-extend sample of given width to 12 bits
	function [11:0] sext;
		input [11:0] raw;
		input [3:0] w;
		reg [11:0] sh;
		begin
			sh = raw << (5'd12 - {1'b0, w});
			sext = $signed(sh) >>> (5'd12 - {1'b0, w});
		end
	endfunction

	wire fifo_in_ready;
	wire samp_push = cs_rise && (short_ok || addr_sample);
	wire [11:0] samp_data = short_ok ? sext(shift_q[11:0], count_q[3:0]) : frame_data;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			phase_q <= `SCMR_RESET_VAL;
			power_q <= `SCMR_RESET_VAL;
			modcfg_q <= `SCMR_RESET_VAL;
		end else if (cs_rise && full_frame && !short_ok) begin
			if (frame_addr == `SCMR_ADDR_PHASE) begin
				phase_q <= frame_data;
			end else if (frame_addr == `SCMR_ADDR_POWER) begin
				power_q <= frame_data;
			end else if (frame_addr == `SCMR_ADDR_MODCFG) begin
				modcfg_q <= frame_data;
			end
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			width_q <= 4'h0;
		end else if (samp_push) begin
			width_q <= short_ok ? count_q[3:0] : 4'hC;
		end
	end

	wire fifo_valid;
	wire [11:0] fifo_data;
	wire fifo_take;
	// Samples wait here until a compare edge; full FIFO drops new ones
	scmr_fifo #(
		.W(DW),
		.DEPTH(DEPTH),
		.AW(2)
	) u_fifo (
		.clk(core_clk),
		.rst(rst),
		.in_valid(samp_push),
		.in_ready(fifo_in_ready),
		.in_data(samp_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_take),
		.out_data(fifo_data)
	);

	reg stage_v_q;
	assign fifo_take = pcc_fall && fifo_valid;
	wire [3:0] mag_raw = modcfg_q[`SCMR_MAG_MSB:`SCMR_MAG_LSB];
	wire [3:0] mag = (mag_raw > `SCMR_MAG_MAX) ? `SCMR_MAG_MAX : mag_raw;
	wire signed [DW+13-1:0] samp_ext = {{13{sample_q[11]}}, sample_q};
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sample_q <= 12'h000;
			stage_v_q <= 1'b0;
			freq_offset <= 25'h0000000;
			offset_valid <= 1'b0;
			fifo_width_q <= 4'h0;
		end else begin
			offset_valid <= 1'b0;
			if (pcc_fall) begin
				stage_v_q <= fifo_valid;
				if (fifo_valid) begin
					sample_q <= fifo_data;
				end
				if (stage_v_q) begin
					freq_offset <= samp_ext <<< mag;
					offset_valid <= 1'b1;
				end
			end
			fifo_width_q <= width_q;
		end
	end

	// Control outputs
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pump_gain <= 5'h00;
			full_power_down <= 1'b0;
			synth_power_down <= 1'b0;
			integer_mode <= 1'b0;
			sigma_delta_off <= 1'b0;
			frac_10bit <= 1'b0;
		end else begin
			pump_gain <= phase_q[`SCMR_GAIN_MSB:`SCMR_GAIN_LSB];
			full_power_down <= power_q[`SCMR_FULLPD_BIT];
			synth_power_down <= power_q[`SCMR_SYNPD_BIT] || power_q[`SCMR_FULLPD_BIT];
			integer_mode <= power_q[`SCMR_INTMODE_BIT];
			sigma_delta_off <= power_q[`SCMR_INTMODE_BIT] || power_q[`SCMR_FULLPD_BIT];
			frac_10bit <= power_q[`SCMR_FRAC10_BIT];
		end
	end

	reg ld_o_q;
	reg ld_oe_n_q;
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ld_o_q <= 1'b0;
			ld_oe_n_q <= 1'b1;
		end else if (phase_q[`SCMR_STEER_BIT]) begin
			// Drive only while steering is asked for, float otherwise
			ld_o_q <= steer_s;
			ld_oe_n_q <= !steer_s;
		end else begin
			// Open collector: pull low when out of lock and not in full power-down, float otherwise
			ld_o_q <= 1'b0;
			ld_oe_n_q <= lock_s || full_power_down;
		end
	end
	assign lock_detect_steer_o = ld_o_q;
	assign lock_detect_steer_oe_n = ld_oe_n_q;

	// monitor source decode, unused codes low
	function mon_pick;
		input [2:0] sel;
		input osc;
		input dref;
		input pcc;
		input loop;
		input test;
		begin
			case (sel)
				`SCMR_MON_OSC: mon_pick = osc;
				`SCMR_MON_REF: mon_pick = dref;
				`SCMR_MON_PD: mon_pick = pcc;
				`SCMR_MON_LOOP: mon_pick = loop;
				`SCMR_MON_TEST: mon_pick = test;
				default: mon_pick = 1'b0;
			endcase
		end
	endfunction
	// Sources are resampled, so only levels well below core_clk show cleanly
	reg mon_q;
	wire [2:0] mon_sel = power_q[`SCMR_MON_MSB:`SCMR_MON_LSB];
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mon_q <= 1'b0;
		end else begin
			mon_q <= mon_pick(mon_sel, osc_s, dref_s, pcc_s, sdat_s, test_s);
		end
	end
	assign monitor_output_o = mon_q;
	assign monitor_output_oe_n = power_q[`SCMR_TRI_BIT];
endmodule

// [test/scmr_sva.sv]
// Port checker for the register bank top.
// Assumes one core clock domain with async high reset.
`timescale 1ns/1ns
module scmr_sva (
	// Clock, reset and inputs
	input wire core_clk,
	input wire rst,
	input wire ser_cs_n,
	input wire phase_compare_clock,
	// Outputs watched
	input wire [4:0] pump_gain,
	input wire full_power_down,
	input wire synth_power_down,
	input wire integer_mode,
	input wire sigma_delta_off,
	input wire frac_10bit,
	input wire monitor_output_oe_n,
	input wire signed [24:0] freq_offset,
	input wire offset_valid
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire [10:0] ctrl;
	logic pcc_q;
	logic [3:0] age_q;
	assign ctrl = {pump_gain, full_power_down, synth_power_down, integer_mode,
		sigma_delta_off, frac_10bit, monitor_output_oe_n};
	// Cycles since the compare clock last fell, saturating
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pcc_q <= 1'b0;
			age_q <= 4'hF;
		end else begin
			pcc_q <= phase_compare_clock;
			if (pcc_q && !phase_compare_clock)
				age_q <= 4'h0;
			else if (age_q != 4'hF)
				age_q <= age_q + 4'h1;
		end
	end
	sequence s_pulse;
		offset_valid ##1 !offset_valid;
	endsequence
	sequence s_still;
		$stable(ctrl) [*3];
	endsequence
	property p_full_syn;
		full_power_down |-> synth_power_down;
	endproperty
	property p_full_sd;
		full_power_down |-> sigma_delta_off;
	endproperty
	property p_int_sd;
		integer_mode |-> sigma_delta_off;
	endproperty
	property p_sd_cause;
		sigma_delta_off |-> integer_mode || full_power_down;
	endproperty
	property p_pulse;
		$rose(offset_valid) |-> s_pulse;
	endproperty
	property p_after_fall;
		offset_valid |-> age_q <= 4'h6;
	endproperty
	property p_hold;
		!offset_valid |-> $stable(freq_offset);
	endproperty
	property p_quiet;
		!ser_cs_n |=> s_still;
	endproperty
	a_full_syn: assert property (p_full_syn)
		else $error("synth powered in full power-down");
	a_full_sd: assert property (p_full_sd)
		else $error("modulator on in full power-down");
	a_int_sd: assert property (p_int_sd)
		else $error("modulator on in integer mode");
	a_sd_cause: assert property (p_sd_cause)
		else $error("modulator off without cause");
	a_pulse: assert property (p_pulse)
		else $error("offset valid longer than one cycle");
	a_after_fall: assert property (p_after_fall)
		else $error("offset valid far from compare fall");
	a_hold: assert property (p_hold)
		else $error("offset changed without valid");
	a_quiet: assert property (p_quiet)
		else $error("control changed during a frame");
endmodule

// [test/scmr_host.sv]
// Serial controller model driving strobe, clock and data pins.
// Assumes core_clk is the 40 ns bench clock; one bit takes 360 ns.
`timescale 1ns/1ns
module scmr_host (
	// Bench clock
	input wire core_clk,
	// Serial pins
	output logic cs_n,
	output logic sclk,
	output logic sdata,
	output logic mpin
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdata = 1'b0;
		mpin = 1'b0;
	end
	task automatic send(input logic [15:0] v, input int n, input bit pin);
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge core_clk);
			cs_n <= 1'b0;
			if (pin)
				mpin <= v[i];
			else
				sdata <= v[i];
			repeat (4) @(negedge core_clk);
			sclk <= 1'b1;
			repeat (4) @(negedge core_clk);
			sclk <= 1'b0;
		end
		repeat (4) @(negedge core_clk);
		cs_n <= 1'b1;
		// Released lines have no pull, so show the opposite level
		@(negedge core_clk);
		sdata <= ~sdata;
		mpin <= ~mpin;
	endtask
endmodule

// [test/scmr_tb_top.sv]
// Bench for the register bank: serial writes, monitor mux, samples.
// Assumes the host model owns the serial pins.
`timescale 1ns/1ns
module scmr_tb_top;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic ref_osc = 1'b1;
	logic div_ref = 1'b0;
	logic pcc = 1'b1;
	logic test_out = 1'b0;
	logic locked = 1'b0;
	logic steer_req = 1'b0;
	logic pcc_run = 1'b0;
	logic [4:0] pcc_cnt = 5'h00;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cycles = 0;
	wire cs_n, sclk, sdata, mpin, ld_o, ld_oe_n, mon_o, mon_oe_n;
	wire full_pd, syn_pd, int_mode, sd_off, frac10, off_valid;
	wire [4:0] gain;
	wire signed [24:0] offset;
	scmr_host scmr_host_inst (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk),
		.sdata(sdata), .mpin(mpin));
	scmr_top scmr_top_inst (.core_clk(core_clk), .rst(rst), .ser_cs_n(cs_n),
		.ser_clk(sclk), .ser_data(sdata), .modulation_input_pin(mpin),
		.ref_osc(ref_osc), .divided_reference(div_ref), .phase_compare_clock(pcc),
		.serial_test_out(test_out), .locked(locked), .steer_req(steer_req),
		.lock_detect_steer_o(ld_o), .lock_detect_steer_oe_n(ld_oe_n),
		.monitor_output_o(mon_o), .monitor_output_oe_n(mon_oe_n), .pump_gain(gain),
		.full_power_down(full_pd), .synth_power_down(syn_pd), .integer_mode(int_mode),
		.sigma_delta_off(sd_off), .frac_10bit(frac10), .freq_offset(offset),
		.offset_valid(off_valid));
	always #20 core_clk = ~core_clk;
	// Compare clock period is 64 core clocks; it can be stopped
	always @(negedge core_clk) begin
		pcc_cnt <= pcc_cnt + 5'h01;
		if (pcc_run && pcc_cnt == 5'h00)
			pcc <= ~pcc;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [24:0] e, input logic [24:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic frame(input logic [15:0] v, input int n, input bit pin);
		scmr_host_inst.send(v, n, pin);
		repeat (10) @(negedge core_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [11:0] d);
		frame({a, d}, 16, 1'b0);
	endtask
	task automatic wait_off(input int e);
		int k;
		k = 0;
		while (off_valid !== 1'b1 && k < 300) begin
			@(negedge core_clk);
			k++;
		end
		chk("offset", 25'(e), offset);
		@(negedge core_clk);
	endtask
	task automatic t_phase;
		wr(4'h6, 12'h01F);
		chk("gain", 25'h1F, gain);
		chk("ld_oe_n", 25'h0, ld_oe_n);
		chk("ld_o", 25'h0, ld_o);
		locked = 1'b1;
		repeat (8) @(negedge core_clk);
		chk("ld_oe_n", 25'h1, ld_oe_n);
		wr(4'h6, 12'h020);
		steer_req = 1'b1;
		repeat (8) @(negedge core_clk);
		chk("gain", 25'h0, gain);
		chk("ld_o", 25'h1, ld_o);
		chk("ld_oe_n", 25'h0, ld_oe_n);
		wr(4'h3, 12'hFFF);
		frame(16'h6FFF, 15, 1'b0);
		chk("gain", 25'h0, gain);
	endtask
	task automatic t_power;
		logic [2:0] c;
		logic f;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			f = (c == 3'h7);
			wr(4'h7, {3'h0, c, 1'b0, f, c[1], c[2], c[0], f});
			chk("mon_oe_n", 25'(f), mon_oe_n);
			if (!f) chk("mon", (c == 3'h0 || c == 3'h4) ? 25'h1 :
				(c == 3'h5) ? 25'(sdata) : 25'h0, mon_o);
			chk("full", 25'(f), full_pd);
			chk("syn", 25'(c[0] | f), syn_pd);
			chk("int", 25'(c[2]), int_mode);
			chk("sd_off", 25'(c[2] | f), sd_off);
			chk("frac", 25'(c[1]), frac10);
		end
		wr(4'h7, 12'h000);
	endtask
	task automatic t_samples;
		int k;
		wr(4'h8, 12'h002);
		pcc_run = 1'b1;
		wr(4'h9, 12'hFFD);
		wait_off(-12);
		wr(4'h8, 12'h03D);
		frame(16'h0001, 2, 1'b1);
		wait_off(8192);
		frame({4'h8, 12'h03F}, 16, 1'b1);
		frame(16'h0800, 12, 1'b1);
		wait_off(-16777216);
		// Stalled compare clock lets the buffer fill and refuse
		pcc_run = 1'b0;
		for (int i = 1; i < 7; i++)
			frame(16'(i), 4, 1'b1);
		pcc_run = 1'b1;
		for (int i = 1; i < 6; i++)
			wait_off(i * 8192);
		k = 0;
		repeat (300) begin
			@(negedge core_clk);
			if (off_valid !== 1'b0)
				k++;
		end
		chk("extra", 25'h0, 25'(k));
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		repeat (4) @(negedge core_clk);
		t_phase();
		t_power();
		t_samples();
		results();
	end
endmodule
bind scmr_top scmr_sva scmr_sva_inst (.core_clk, .rst, .ser_cs_n, .phase_compare_clock,
	.pump_gain, .full_power_down, .synth_power_down, .integer_mode, .sigma_delta_off,
	.frac_10bit, .monitor_output_oe_n, .freq_offset, .offset_valid);
